// File: rtl/tdio_pkg.sv
// constants, register map and carrier types of the time-stamped dio fifo unit
// assumes one 100 MHz clock; each clock is one 10 ns time stamp tick
package tdio_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int STAMP_NS = 10;
  localparam int STAMP_CYC = (STAMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // byte offsets; pairs differ in bit 2 only (fifo 1 at the lower word)
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_DIR = 8'h04;
  localparam logic [7:0] A_IMASK = 8'h08;
  localparam logic [7:0] A_OMASK = 8'h10;
  localparam logic [7:0] A_MODE = 8'h18;
  localparam logic [7:0] A_DOUT = 8'h20;
  localparam logic [7:0] A_ILEVEL = 8'h28;
  localparam logic [7:0] A_ISTAMP = 8'h30;
  localparam logic [7:0] A_IFILL = 8'h38;
  localparam logic [7:0] A_OPAT = 8'h40;
  localparam logic [7:0] A_OSTAMP = 8'h48;
  localparam logic [7:0] A_OFREE = 8'h50;
  localparam logic [7:0] A_OCNT = 8'h58;
  localparam logic [7:0] A_TIMER = 8'h60;
  // command word fields
  localparam int CMD_OCLR = 0;
  localparam int CMD_ICLR = 2;
  localparam int CMD_SYNC = 4;
  localparam int CMD_START = 8;
  // output modes
  localparam logic [1:0] MODE_ABS = 2'h1;
  localparam logic [1:0] MODE_REL = 2'h3;
  localparam logic [1:0] MODE_RST = MODE_ABS;
  // geometry
  localparam logic [8:0] DEPTH = 9'h1FF;
  localparam int NCH = 61;
  localparam int NOUT = 42;
  localparam int NGRP = 6;
  localparam int GRP_SZ = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {OF_HALT = 2'b01, OF_RUN = 2'b10} run_e;
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axi_req_s;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_s;
  typedef struct packed {
    axi_rsp_s rsp;
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [NGRP-1:0] dir;
    logic [1:0][31:0] imask;
    logic [1:0][31:0] omask;
    logic [1:0][1:0] mode;
    logic [1:0][31:0] dout;
    logic [1:0][31:0] stamp_hold;
    logic [1:0][31:0] wpat;
    logic [1:0][8:0] iwp, irp, ifill, owp, orp, ofill;
    run_e [1:0] run;
    logic [1:0][31:0] ocnt;
    logic [1:0][31:0] flvl;
    logic [1:0][31:0] prev;
    logic [31:0] timer;
    logic [NCH-1:0] sync1, sync2;
    logic [NOUT-1:0] dio_o, dio_oe;
  } state_s;
endpackage

// File: rtl/tdio_fifo_unit.sv
// time-stamped digital i/o unit: two capture fifos, two timed output fifos
// assumes an axi4-lite master on aclk and asynchronous pins on dio_i
// Operation
// - each input fifo reports its fill count, 0 to 511
// - a full input fifo drops new captures and keeps stored entries
// - reading the level word pops the oldest pair; stamp word follows
// - input fifo 1 maps channels 31..0, fifo 2 bits 28..0 to 60..32
// - captured stamps count 10 ns ticks
// - each output fifo has a 32-bit counter, +1 per 10 ns while running, held while halted, wrapping
// - clearing an output fifo zeroes its counter
// - clearing halts generation and drops pending pairs
// - after a clear only a start command resumes output
// - sync command clears the output fifos like the per-fifo clear
// - per-fifo enable mask picks driven channels, same bit mapping
// - fifo edges reach only channels configured as outputs
// - channels 0..41 set in groups as in or out; 42..60 inputs
// - direct output writes affect only channels not fifo-selected
// - output fifo holds 511 pairs and reports free entries
// - on counter equal to head stamp drive pattern, pop, in order
// - mode 1 absolute stamps, mode 3 stamps relative to last output
// - start command with two-bit select runs fifos from zero
// - capture samples each 10 ns and pushes pattern with timer
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module tdio_fifo_unit
  import tdio_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire axi_req_s s_axi_req,
  output axi_rsp_s s_axi_rsp,
  input wire logic [NCH-1:0] dio_i,
  output logic [NOUT-1:0] dio_o,
  output logic [NOUT-1:0] dio_oe
);
  state_s s_q, s_d;
  logic [63:0] imem [2][512];
  logic [63:0] omem [2][512];
  logic [1:0][63:0] ihead, ohead, ipdat, opdat;
  logic [1:0] ipush, ipop, opush, fire, oclr, iclr, start;
  logic sync;
  logic [NOUT-1:0] dirx;
  logic [1:0][31:0] view, emask;

  // channel direction groups of eight, expanded per channel
  function automatic logic [NOUT-1:0] dir_expand(input logic [NGRP-1:0] d);
    logic [NOUT-1:0] r;
    r = '0;
    for (int i = 0; i < NOUT; i++) begin
      r[i] = d[i / GRP_SZ];
    end
    return r;
  endfunction

  // fifo 2 has no channels behind bits 31:29
  function automatic logic [31:0] fmask(input int k, input logic [31:0] v);
    return (k == 1) ? {3'h0, v[28:0]} : v;
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] st);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) r[b*8 +: 8] = d[b*8 +: 8];
    end
    return r;
  endfunction

  // async-read heads; the pointer flops give the registered boundary
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      ihead[k] = imem[k][s_q.irp[k]];
      ohead[k] = omem[k][s_q.orp[k]];
    end
  end

  // next-state logic: bus slave, capture side, output side, pins
  always_comb begin
    logic [31:0] rd;
    logic [1:0] rr;
    logic [7:0] a;
    logic [31:0] chg;
    int k;
    rd = '0;
    rr = RESP_OKAY;
    a = '0;
    chg = '0;
    k = 0;
    s_d = s_q;
    ipush = '0;
    ipop = '0;
    opush = '0;
    fire = '0;
    oclr = '0;
    iclr = '0;
    start = '0;
    sync = 1'b0;
    ipdat = '0;
    opdat = '0;
    dirx = dir_expand(s_q.dir);
    // only channels that are inputs can be monitored
    emask[0] = s_q.imask[0] & ~dirx[31:0];
    emask[1] = s_q.imask[1] & {3'h0, 19'h7FFFF, ~dirx[41:32]};
    view[0] = s_q.sync2[31:0];
    view[1] = {3'h0, s_q.sync2[60:32]};
    s_d.sync1 = dio_i;
    s_d.sync2 = s_q.sync1;
    // write channel: address and data taken in either order
    if (s_q.rsp.bvalid && s_axi_req.bready) s_d.rsp.bvalid = 1'b0;
    if (s_axi_req.awvalid && s_q.rsp.awready) begin
      s_d.aw_hold = 1'b1;
      s_d.aw_addr = s_axi_req.awaddr;
    end
    if (s_axi_req.wvalid && s_q.rsp.wready) begin
      s_d.w_hold = 1'b1;
      s_d.wdata = s_axi_req.wdata;
      s_d.wstrb = s_axi_req.wstrb;
    end
    if (s_q.aw_hold && s_q.w_hold && !s_q.rsp.bvalid) begin
      a = s_q.aw_addr;
      k = int'(a[2]);
      s_d.aw_hold = 1'b0;
      s_d.w_hold = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp = RESP_OKAY;
      case (a[7:3])
        A_CMD[7:3]: begin
          if (!a[2]) begin
            oclr = s_q.wdata[CMD_OCLR +: 2];
            iclr = s_q.wdata[CMD_ICLR +: 2];
            sync = s_q.wdata[CMD_SYNC];
            start = s_q.wdata[CMD_START +: 2];
          end else begin
            s_d.dir = NGRP'(wmerge({26'h0, s_q.dir}, s_q.wdata, s_q.wstrb));
          end
        end
        A_IMASK[7:3]: s_d.imask[k] = fmask(k, wmerge(s_q.imask[k], s_q.wdata, s_q.wstrb));
        A_OMASK[7:3]: s_d.omask[k] = fmask(k, wmerge(s_q.omask[k], s_q.wdata, s_q.wstrb));
        A_MODE[7:3]: s_d.mode[k] = s_q.wdata[1:0];
        A_DOUT[7:3]: s_d.dout[k] = wmerge(s_q.dout[k], s_q.wdata, s_q.wstrb);
        A_OPAT[7:3]: s_d.wpat[k] = s_q.wdata;
        A_OSTAMP[7:3]: begin
          // a push into a full fifo is ignored
          opush[k] = (s_q.ofill[k] != DEPTH);
          opdat[k] = {s_q.wpat[k], s_q.wdata};
        end
        default: s_d.rsp.bresp = RESP_SLVERR;
      endcase
    end
    s_d.rsp.awready = !s_d.aw_hold;
    s_d.rsp.wready = !s_d.w_hold;
    // read channel: one read at a time, answered one cycle after ar
    if (s_q.rsp.rvalid && s_axi_req.rready) s_d.rsp.rvalid = 1'b0;
    if (s_axi_req.arvalid && s_q.rsp.arready) begin
      a = s_axi_req.araddr;
      k = int'(a[2]);
      case (a[7:3])
        A_CMD[7:3]: rd = a[2] ? {26'h0, s_q.dir} : 32'h0;
        A_IMASK[7:3]: rd = s_q.imask[k];
        A_OMASK[7:3]: rd = s_q.omask[k];
        A_MODE[7:3]: rd = {30'h0, s_q.mode[k]};
        A_DOUT[7:3]: rd = s_q.dout[k];
        A_ILEVEL[7:3]: begin
          // popping on the level word keeps the pair together
          if (s_q.ifill[k] != 9'h0) begin
            rd = ihead[k][63:32];
            ipop[k] = 1'b1;
            s_d.stamp_hold[k] = ihead[k][31:0];
          end
        end
        A_ISTAMP[7:3]: rd = s_q.stamp_hold[k];
        A_IFILL[7:3]: rd = {23'h0, s_q.ifill[k]};
        A_OPAT[7:3]: rd = s_q.wpat[k];
        A_OFREE[7:3]: rd = {23'h0, DEPTH - s_q.ofill[k]};
        A_OCNT[7:3]: rd = s_q.ocnt[k];
        A_TIMER[7:3]: begin
          if (a[2]) rr = RESP_SLVERR;
          else rd = s_q.timer;
        end
        default: rr = RESP_SLVERR;
      endcase
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rdata = rd;
      s_d.rsp.rresp = rr;
    end
    s_d.rsp.arready = !s_d.rsp.rvalid;
    // capture timer, one tick per 10 ns clock
    s_d.timer = sync ? 32'h0 : s_q.timer + 32'h1;
    iclr = iclr | {sync, sync};
    oclr = oclr | {sync, sync};
    for (int f = 0; f < 2; f++) begin
      // capture: any change on monitored channels pushes the full pattern
      chg = (view[f] ^ s_q.prev[f]) & emask[f];
      s_d.prev[f] = view[f];
      ipdat[f] = {view[f], s_q.timer};
      ipush[f] = (|chg) && (s_q.ifill[f] != DEPTH) && !iclr[f];
      if (iclr[f]) begin
        s_d.iwp[f] = '0;
        s_d.irp[f] = '0;
        s_d.ifill[f] = '0;
      end else begin
        s_d.iwp[f] = s_q.iwp[f] + {8'h0, ipush[f]};
        s_d.irp[f] = s_q.irp[f] + {8'h0, ipop[f]};
        s_d.ifill[f] = s_q.ifill[f] + {8'h0, ipush[f]} - {8'h0, ipop[f]};
      end
      // output: head pair fires when counter meets its stamp
      fire[f] = (s_q.run[f] == OF_RUN) && (s_q.ofill[f] != 9'h0) &&
                (s_q.ocnt[f] == ohead[f][31:0]);
      if (oclr[f]) begin
        fire[f] = 1'b0;
        opush[f] = 1'b0;
        s_d.owp[f] = '0;
        s_d.orp[f] = '0;
        s_d.ofill[f] = '0;
        s_d.ocnt[f] = '0;
        s_d.run[f] = OF_HALT;
      end else begin
        if (start[f]) begin
          s_d.run[f] = OF_RUN;
          s_d.ocnt[f] = '0;
        end else begin
          case (s_q.run[f])
            OF_HALT: s_d.run[f] = OF_HALT;
            OF_RUN: begin
              // relative mode counts from the previous output
              if (fire[f] && s_q.mode[f] == MODE_REL) s_d.ocnt[f] = 32'h1;
              else s_d.ocnt[f] = s_q.ocnt[f] + 32'h1;
            end
            default: s_d.run[f] = OF_HALT;
          endcase
        end
        if (fire[f]) s_d.flvl[f] = ohead[f][63:32];
        s_d.owp[f] = s_q.owp[f] + {8'h0, opush[f]};
        s_d.orp[f] = s_q.orp[f] + {8'h0, fire[f]};
        s_d.ofill[f] = s_q.ofill[f] + {8'h0, opush[f]} - {8'h0, fire[f]};
      end
    end
    // pins: fifo owns selected channels, direct register the rest
    s_d.dio_oe = dirx;
    s_d.dio_o = ({s_q.omask[1][9:0], s_q.omask[0]} & {s_q.flvl[1][9:0], s_q.flvl[0]}) |
                (~{s_q.omask[1][9:0], s_q.omask[0]} & {s_q.dout[1][9:0], s_q.dout[0]});
  end

  // state register; memories below carry no reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.mode <= {MODE_RST, MODE_RST};
      s_q.run[0] <= OF_HALT;
      s_q.run[1] <= OF_HALT;
    end else begin
      s_q <= s_d;
    end
  end

  // pair storage
  always_ff @(posedge aclk) begin
    for (int f = 0; f < 2; f++) begin
      if (ipush[f]) imem[f][s_q.iwp[f]] <= ipdat[f];
      if (opush[f]) omem[f][s_q.owp[f]] <= opdat[f];
    end
  end

  assign s_axi_rsp = s_q.rsp;
  assign dio_o = s_q.dio_o;
  assign dio_oe = s_q.dio_oe;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_in_full;
    (s_q.ifill[0] == DEPTH && !ipop[0] && !iclr[0]) |-> !ipush[0] ##1 s_q.ifill[0] == DEPTH;
  endproperty
  a_in_full: assert property (p_in_full) else $error("full input fifo accepted a pair");
  property p_in_pop;
    (ipop[0] && !ipush[0] && !iclr[0]) |=> s_q.ifill[0] == $past(s_q.ifill[0]) - 9'h1;
  endproperty
  a_in_pop: assert property (p_in_pop) else $error("read did not remove one pair");
  property p_in_empty;
    (s_q.ifill[1] == 9'h0 && !ipush[1]) |=> s_q.ifill[1] == 9'h0;
  endproperty
  a_in_empty: assert property (p_in_empty) else $error("empty fifo count changed");
  property p_ocnt;
    (s_q.run[0] == OF_RUN && !oclr[0] && !start[0] && !fire[0])
      |=> s_q.ocnt[0] == $past(s_q.ocnt[0]) + 32'h1;
  endproperty
  a_ocnt: assert property (p_ocnt) else $error("output counter did not tick");
  property p_clr;
    oclr[0] |=> s_q.ocnt[0] == 32'h0 && s_q.ofill[0] == 9'h0 && s_q.run[0] == OF_HALT;
  endproperty
  a_clr: assert property (p_clr) else $error("clear left state behind");
  property p_halt;
    (s_q.run[1] == OF_HALT && !start[1]) |=> s_q.run[1] == OF_HALT && !fire[1];
  endproperty
  a_halt: assert property (p_halt) else $error("output resumed without start");
  property p_sync;
    sync |=> s_q.ofill == '0 && s_q.run == {OF_HALT, OF_HALT};
  endproperty
  a_sync: assert property (p_sync) else $error("sync did not clear output fifos");
  property p_fire;
    fire[0] |=> s_q.flvl[0] == $past(ohead[0][63:32]) ##1 s_q.dio_o[0] ==
      ($past(s_q.omask[0][0]) ? $past(s_q.flvl[0][0]) : $past(s_q.dout[0][0]));
  endproperty
  a_fire: assert property (p_fire) else $error("fired pattern not driven");
  property p_oe;
    ##1 s_q.dio_oe == $past(dir_expand(s_q.dir));
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable not from direction");
  property p_rel;
    (fire[0] && s_q.mode[0] == MODE_REL && !oclr[0] && !start[0]) |=> s_q.ocnt[0] == 32'h1;
  endproperty
  a_rel: assert property (p_rel) else $error("relative counter not restarted");
  property p_start;
    (start[1] && !oclr[1]) |=> s_q.run[1] == OF_RUN && s_q.ocnt[1] == 32'h0;
  endproperty
  a_start: assert property (p_start) else $error("start did not run from zero");
  property p_bhold;
    (s_q.rsp.bvalid && !s_axi_req.bready) |=> s_q.rsp.bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped early");

  property p_cv_fire;
    fire[0] ##[1:40] fire[0];
  endproperty
  c_cv_fire: cover property (p_cv_fire);
  property p_cv_drop;
    s_q.ifill[0] == DEPTH && (|((view[0] ^ s_q.prev[0]) & emask[0]));
  endproperty
  c_cv_drop: cover property (p_cv_drop);
  property p_cv_pop;
    ipush[1] ##[1:20] ipop[1];
  endproperty
  c_cv_pop: cover property (p_cv_pop);
endmodule
`default_nettype wire

// File: test/dio_pin_model.sv
// pin-side model: resolves driven channels and feeds the capture inputs
// assumes the bench sets the level of every channel that nobody drives
`timescale 1ns/1ps
`default_nettype none
module dio_pin_model
  import tdio_pkg::*;
(
  input wire logic [NOUT-1:0] dio_o,
  input wire logic [NOUT-1:0] dio_oe,
  input wire logic [NCH-1:0] ext_lvl,
  output logic [NCH-1:0] dio_i
);
  // a driven channel reads back its own level; 42..60 are never driven
  always_comb begin
    dio_i = ext_lvl;
    dio_i[NOUT-1:0] = (dio_o & dio_oe) | (ext_lvl[NOUT-1:0] & ~dio_oe);
  end
endmodule
`default_nettype wire

// File: test/testbench.sv
// bench of the time-stamped dio unit: capture, timed output, commands
// assumes the pin model on the channel side; the bench is the bus master
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tdio_pkg::*;
  localparam logic [31:0] OE1 = 32'hFFFFFF00;
  logic aclk, aresetn;
  axi_req_s req;
  axi_rsp_s rsp;
  logic [NCH-1:0] lvl, dio_i;
  logic [NOUT-1:0] dio_o, dio_oe;
  logic [31:0] seed = 32'hCD31;
  logic [31:0] rd, m, d, p, q;
  logic [1:0] rs;
  logic slow_b = 1'b0;
  int n_fail = 0, n_checks = 0, cyc = 0;
  logic [31:0] pq[$];
  int tq[$];

  tdio_fifo_unit tdio_fifo_unit_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_req(req),
    .s_axi_rsp(rsp), .dio_i(dio_i), .dio_o(dio_o), .dio_oe(dio_oe));
  dio_pin_model dio_pin_model_inst (.dio_o(dio_o), .dio_oe(dio_oe), .ext_lvl(lvl),
    .dio_i(dio_i));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected levels of fifo 1 output channels: fifo bits under the mask, direct elsewhere
  function automatic logic [31:0] lv(input logic [31:0] pat);
    return ((pat & m) | (d & ~m)) & OE1;
  endfunction
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // ready lines are sampled at the edge; with slow_b set bready waits for bvalid,
  // so the response must stand until the master finally takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int t;
    t = 0;
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= v;
    req.wstrb <= 4'hF;
    req.bready <= !slow_b;
    do begin
      @(posedge aclk);
      t++;
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1 && !req.bready) req.bready <= 1'b1;
    end while (!(rsp.bvalid === 1'b1 && req.bready) && t < 40);
    chk("bresp", {1'b1, RESP_OKAY}, {rsp.bvalid, rsp.bresp});
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    int t;
    t = 0;
    req.arvalid <= 1'b1;
    req.araddr <= a;
    do begin
      @(posedge aclk);
      t++;
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1 && t < 40);
    v = rsp.rdata;
    r = rsp.rresp;
  endtask
  // read and compare; an okay response is part of the expected value
  task automatic rc(input logic [7:0] a, input logic [63:0] e, input string nm);
    logic [31:0] v;
    logic [1:0] r;
    rdr(a, v, r);
    chk(nm, e, {30'h0, r, v});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 10000 cycles
  initial begin
    cy(30000);
    n_fail++;
    wrap_up();
  end

  initial begin
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    lvl = '0;
    aresetn = 1'b0;
    cy(3);
    aresetn <= 1'b1;
    cy(2);
    rc(A_DIR, 0, "dir reset");
    rc(A_OFREE, DEPTH, "ofree reset");
    rc(A_IFILL, 0, "ifill reset");
    rdr(8'h64, rd, rs);
    chk("unmapped resp", RESP_SLVERR, rs);
    $display("test reset done");
    // random level changes on fifo 1 with uneven gaps
    m = xs() | 32'h1;
    wr(A_IMASK, m);
    wr(A_CMD, 32'h4);
    p = 0;
    for (int i = 0; i < 8; i++) begin
      p = p ^ ((xs() & m) | 32'h1);
      lvl[31:0] <= p;
      pq.push_back(p);
      tq.push_back(cyc);
      cy(3 + int'(xs() % 8));
    end
    cy(4);
    rc(A_IFILL, 8, "ifill");
    for (int i = 0; i < 8; i++) begin
      rc(A_ILEVEL, pq[i], "level");
      rdr(A_ISTAMP, rd, rs);
      if (i > 0) chk("stamp gap", tq[i] - tq[i-1], rd - q);
      q = rd;
    end
    rc(A_ILEVEL, 0, "empty level");
    rc(A_IFILL, 0, "empty fill");
    wr(A_IMASK | 8'h04, 32'h1FFFFFFF);
    d = (xs() & 32'h1FFFFFFF) | 32'h1;
    lvl[60:32] <= d[28:0];
    cy(6);
    rc(A_ILEVEL | 8'h04, d, "fifo2 level");
    $display("test capture done");
    // more changes than room: the oldest entries must survive
    lvl <= '0;
    cy(4);
    wr(A_CMD, 32'h10);
    wr(A_IMASK, 32'h1);
    for (int i = 0; i < 520; i++) begin
      lvl[0] <= ~lvl[0];
      cy(2);
    end
    cy(4);
    rc(A_IFILL, DEPTH, "full fill");
    rc(A_ILEVEL, 1, "full first");
    rc(A_ILEVEL, 0, "full second");
    $display("test overflow done");
    // timed output on fifo 1, partial mask over direct levels, group 0 left as input
    wr(A_CMD, 32'h1);
    slow_b = 1'b1;
    wr(A_DIR, 32'h0E);
    m = xs();
    d = xs();
    wr(A_OMASK, m);
    wr(A_DOUT, d);
    slow_b = 1'b0;
    cy(3);
    chk("oe", 42'h0FFFFFF00, dio_oe);
    chk("direct", lv(32'h0), dio_o[31:0] & ~m & OE1);
    p = xs();
    wr(A_OPAT, p);
    wr(A_OSTAMP, 30);
    wr(A_OPAT, ~p);
    wr(A_OSTAMP, 60);
    rc(A_OFREE, DEPTH - 2, "ofree loaded");
    wr(A_CMD, 32'h100);
    cy(45);
    chk("fire 1", lv(p), dio_o[31:0] & OE1);
    cy(30);
    chk("fire 2", lv(~p), dio_o[31:0] & OE1);
    rc(A_OFREE, DEPTH, "ofree drained");
    rdr(A_OCNT, rd, rs);
    cy(20);
    rdr(A_OCNT, q, rs);
    chk("counter step", 22, q - rd);
    $display("test output done");
    // clear halts and drops; pushes alone do not restart
    wr(A_OPAT, p);
    wr(A_OSTAMP, 200);
    wr(A_CMD, 32'h1);
    rc(A_OFREE, DEPTH, "ofree clear");
    rc(A_OCNT, 0, "ocnt clear");
    wr(A_OSTAMP, 10);
    cy(30);
    chk("halted", lv(~p), dio_o[31:0] & OE1);
    rc(A_OFREE, DEPTH - 1, "ofree halted");
    wr(A_CMD, 32'h10);
    rc(A_OFREE, DEPTH, "ofree sync");
    rc(A_OCNT, 0, "ocnt sync");
    // relative stamps: an equal second stamp fires soon, not after a wrap
    wr(A_MODE, MODE_REL);
    wr(A_OPAT, p);
    wr(A_OSTAMP, 20);
    wr(A_OPAT, ~p);
    wr(A_OSTAMP, 20);
    wr(A_CMD, 32'h100);
    cy(60);
    chk("relative", lv(~p), dio_o[31:0] & OE1);
    rc(A_OFREE, DEPTH, "ofree relative");
    $display("test clear and modes done");
    // fill a halted output fifo past its depth
    wr(A_CMD, 32'h1);
    for (int i = 0; i < 512; i++) wr(A_OSTAMP, xs());
    rc(A_OFREE, 0, "ofree full");
    $display("test output full done");
    // fifo 2 pins: groups 4 and 5 as outputs, two channels owned by the fifo
    wr(A_DIR, 32'h30);
    wr(A_OMASK | 8'h04, 32'hE0000003);
    rc(A_OMASK | 8'h04, 32'h3, "omask 2");
    wr(A_DOUT | 8'h04, d);
    cy(3);
    chk("oe 2", 42'h3FF00000000, dio_oe);
    chk("direct 2", {d[9:2], 2'b00}, dio_o[41:32]);
    $display("test fifo 2 pins done");
    wrap_up();
  end
endmodule
`default_nettype wire
